// *** spms_pkg.sv ***
/*
  Shared constants and types of the serial peripheral port: register
  offsets, field positions, reset values, bit-rate divisor table and the
  pin carrier. Assumes an 8-bit register port and a single clock.
*/
`default_nettype none

package spms_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPMS_CTRL_OFS = 8'h28;
  localparam logic [7:0] SPMS_STAT_OFS = 8'h29;
  localparam logic [7:0] SPMS_DATA_OFS = 8'h2A;
  localparam logic [7:0] SPMS_IRQ_ST_OFS = 8'h2B;
  localparam logic [7:0] SPMS_IRQ_MASK_OFS = 8'h2C;
  localparam logic [7:0] SPMS_SYSTEM_OPTIONS_TWO_OFS = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_IE = 7;
  localparam int CTRL_EN = 6;
  localparam int CTRL_OD = 5;
  localparam int CTRL_MS = 4;
  localparam int CTRL_POL = 3;
  localparam int CTRL_PHA = 2;
  localparam int SYSTEM_OPTIONS_TWO_LSB = 3;
  localparam int SYSTEM_OPTIONS_TWO_PRE = 2;
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_MODE_FAULT_FLAG = 4;

  // ----------------------------------------------------------------
  // Reset values and fixed masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] SYSTEM_OPTIONS_TWO_RST = 8'h00;
  localparam logic [7:0] SYSTEM_OPTIONS_TWO_MASK = 8'h0C;
  localparam logic [7:0] CTRL_FAULT_CLR = 8'h50;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [3:0] SYNC_RST = 4'h1;
  localparam logic [3:0] EDGE_LAST = 4'hF;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spms_pins_t;

  typedef enum logic {SPMS_IDLE, SPMS_XFER} spms_state_t;

  // Divisor of the system clock for one serial clock period
  function automatic logic [7:0] spms_divisor(input logic [2:0] sel);
    logic [7:0] d;
    d = 8'h02;
    case (sel)
      3'h0: d = 8'h02;
      3'h1: d = 8'h04;
      3'h2: d = 8'h10;
      3'h3: d = 8'h20;
      3'h4: d = 8'h08;
      3'h5: d = 8'h10;
      3'h6: d = 8'h40;
      3'h7: d = 8'h80;
      default: d = 8'h02;
    endcase
    return d;
  endfunction

endpackage

`default_nettype wire

// *** spms_port.sv ***
/*
  Serial peripheral port, master or slave, with its register file and
  interrupt. Assumes a register master on ref_clk_i that keeps strobes
  one cycle long, and pads outside that resolve pins from the enables.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// (R01) Interrupt only while enable bit is one
// (R02) Port works only when system enable set
// (R03) Open-drain pins when wired-OR option set
// (R04) Master select picks master or slave
// (R05) Polarity sets idle level, phase sets sample edge
// (R06) Bit order MSB or LSB first
// (R07) Master clock divided by rate field
// (R08) Prescale bit adds divide by four
// (R09) Done flag after eight serial clocks
// (R10) Status read then data access clears flags
// (R11) Data write during transfer sets collision
// (R12) Select low in master mode faults, stops
// (R13) Status read then control write clears fault
// (R14) Receive double buffered, transmit single
// (R15) Master up to half, slave limited rate
// (R16) External master holds select, supplies clock
module spms_port
  import spms_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  input wire spms_pins_t pin_i,
  input wire logic ss_n_i,
  output spms_pins_t pin_o,
  output spms_pins_t pin_oe_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Release through two flops so every register leaves reset together
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic sck_d_r;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_s;

  // Order {sck, mosi, miso, select}; third sck flop feeds edge detect
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sck_d_r <= 1'b0;
    end else begin
      sync1_r <= {pin_i.sck, pin_i.mosi, pin_i.miso, ss_n_i};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[3];
    end
  end
  assign sck_s = sync2_r[3];
  assign mosi_s = sync2_r[2];
  assign miso_s = sync2_r[1];
  assign ss_s = sync2_r[0];

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] system_options_two_r;
  logic done_r;
  logic write_collision_flag_r;
  logic mode_fault_flag_r;
  logic [2:0] arm_r;
  logic [7:0] rx_buf_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_mask_r;
  logic [7:0] rdata_r;
  logic irq_r;

  logic sel_ctrl;
  logic sel_stat;
  logic sel_data;
  logic sel_system_options_two;
  logic sel_ist;
  logic sel_imask;
  logic ctrl_wr;
  logic stat_rd;
  logic data_wr;
  logic data_acc;

  // Address decode; unmapped reads answer zero, writes are dropped
  assign sel_ctrl = (addr_i == SPMS_CTRL_OFS);
  assign sel_stat = (addr_i == SPMS_STAT_OFS);
  assign sel_data = (addr_i == SPMS_DATA_OFS);
  assign sel_system_options_two = (addr_i == SPMS_SYSTEM_OPTIONS_TWO_OFS);
  assign sel_ist = (addr_i == SPMS_IRQ_ST_OFS);
  assign sel_imask = (addr_i == SPMS_IRQ_MASK_OFS);
  assign ctrl_wr = wr_i & sel_ctrl;
  assign stat_rd = rd_i & sel_stat;
  assign data_wr = wr_i & sel_data;
  assign data_acc = (wr_i | rd_i) & sel_data;

  // Control fields
  logic ie;
  logic en;
  logic od;
  logic mst;
  logic pol;
  logic pha;
  logic lsb;
  logic [2:0] rate;

  assign ie = ctrl_r[CTRL_IE];
  assign en = ctrl_r[CTRL_EN];
  assign od = ctrl_r[CTRL_OD];
  assign mst = ctrl_r[CTRL_MS];
  assign pol = ctrl_r[CTRL_POL];
  assign pha = ctrl_r[CTRL_PHA];
  assign lsb = system_options_two_r[SYSTEM_OPTIONS_TWO_LSB];
  assign rate = {system_options_two_r[SYSTEM_OPTIONS_TWO_PRE], ctrl_r[1:0]}; // R08

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  spms_state_t state_r;
  logic [3:0] edge_cnt_r;
  logic [6:0] div_cnt_r;
  logic sck_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [5:0] lag_r;

  logic [7:0] divisor;
  logic [6:0] half_m1;
  logic xfer;
  logic slv_act;
  logic busy;
  logic tick;
  logic slv_edge;
  logic edge_ev;
  logic lead;
  logic sample;
  logic shift;
  logic in_bit;
  logic out_bit;
  logic done_ev;
  logic last_edge;
  logic fault;
  logic start;
  logic write_collision_flag_ev;
  logic [7:0] rx_nxt;

  // One serial period in system clocks; divisor 2 is the fastest
  // master rate, half of the 20 MHz clock
  assign divisor = spms_divisor(rate); // R07 R15
  assign half_m1 = divisor[7:1] - 7'h01;
  assign xfer = (state_r == SPMS_XFER);
  // Slave is steered only by the external master's select and clock;
  // the synchroniser needs its clock below a quarter of ref_clk_i
  assign slv_act = en & ~mst & ~ss_s; // R04 R16 R15
  assign busy = xfer | slv_act | (|lag_r[5:3]);
  assign tick = xfer & (div_cnt_r == half_m1); // R07
  assign slv_edge = slv_act & (sck_s != sck_d_r);
  assign edge_ev = tick | slv_edge;
  // Even edge count is the leading edge of a bit
  assign lead = ~edge_cnt_r[0];
  // Phase zero samples on leading edges, phase one on trailing
  // Master data reach us through the pin synchroniser, three cycles late
  assign sample = lag_r[2] | (slv_edge & (lead ^ pha)); // R05
  // Phase one skips the very first leading edge: bit 7, or bit 0 when LSB first, already stands
  assign shift = edge_ev & ~(lead ^ pha) & ~(pha & edge_cnt_r == 4'h0);
  assign in_bit = mst ? miso_s : mosi_s;
  assign out_bit = lsb ? tx_r[0] : tx_r[7]; // R06
  assign last_edge = edge_ev & (edge_cnt_r == EDGE_LAST); // R09
  assign done_ev = lag_r[5] | (last_edge & ~xfer); // R09
  assign fault = en & mst & ~ss_s; // R12
  assign start = data_wr & en & mst & ~busy & ~fault & ~mode_fault_flag_r; // R02
  assign write_collision_flag_ev = data_wr & busy; // R11
  assign rx_nxt = ~sample ? rx_r :
                  lsb ? {in_bit, rx_r[7:1]} : {rx_r[6:0], in_bit}; // R06

  // Master sequencing; a fault drops the transfer at once
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SPMS_IDLE;
    end else if (fault) begin
      state_r <= SPMS_IDLE; // R12
    end else if (start) begin
      state_r <= SPMS_XFER; // R04
    end else if (last_edge & xfer) begin
      state_r <= SPMS_IDLE;
    end
  end

  // Rate divider and edge counter; sixteen edges make eight clocks
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 7'h00;
      edge_cnt_r <= 4'h0;
      lag_r <= 6'h00;
    end else begin
      div_cnt_r <= (!xfer || tick) ? 7'h00 : div_cnt_r + 7'h01;
      lag_r <= fault ? 6'h00 : {lag_r[4:3], last_edge & xfer, lag_r[1:0], tick & (lead ^ pha)};
      if (!busy || start) begin
        edge_cnt_r <= 4'h0;
      end else if (edge_ev) begin
        edge_cnt_r <= edge_cnt_r + 4'h1; // R09
      end
    end
  end

  // Serial clock rests at the polarity level between characters
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_r <= 1'b0;
    end else if (!xfer) begin
      sck_r <= pol; // R05
    end else if (tick) begin
      sck_r <= ~sck_r;
    end
  end

  // Transmit is single buffered: a write goes straight to the shifter
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rx_buf_r <= 8'h00;
    end else begin
      if (data_wr && !busy) begin
        tx_r <= wdata_i; // R14
      end else if (shift) begin
        tx_r <= lsb ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0}; // R06
      end
      rx_r <= rx_nxt;
      if (done_ev) begin
        rx_buf_r <= rx_nxt; // R14
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and clear sequences
  // ----------------------------------------------------------------
  logic done_nxt;
  logic write_collision_flag_nxt;
  logic mode_fault_flag_nxt;

  // A new event in the clearing cycle wins over the clear
  assign done_nxt = done_ev | (done_r & ~(data_acc & arm_r[0])); // R09 R10
  assign write_collision_flag_nxt = write_collision_flag_ev | (write_collision_flag_r & ~(data_acc & arm_r[1])); // R11 R10
  assign mode_fault_flag_nxt = fault | (mode_fault_flag_r & ~(ctrl_wr & arm_r[2])); // R12 R13

  // Status read arms a clear only for flags seen set by that read
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      arm_r <= 3'h0;
    end else begin
      done_r <= done_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      mode_fault_flag_r <= mode_fault_flag_nxt;
      if (stat_rd) begin
        arm_r <= {mode_fault_flag_r, write_collision_flag_r, done_r}; // R10 R13
      end else begin
        arm_r <= arm_r & {~ctrl_wr, ~data_acc, ~data_acc};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_nxt;

  // Fault clears enable and master select so the port stops driving
  assign ctrl_nxt = (ctrl_wr ? wdata_i : ctrl_r) &
                    (fault ? ~CTRL_FAULT_CLR : 8'hFF); // R12

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      system_options_two_r <= SYSTEM_OPTIONS_TWO_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_i && sel_system_options_two) begin
        system_options_two_r <= wdata_i & SYSTEM_OPTIONS_TWO_MASK;
      end
      if (wr_i && sel_imask) begin
        irq_mask_r <= wdata_i[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;

  // Bit 0 done, bit 1 collision, bit 2 fault; write one to clear
  assign irq_ev = {fault, write_collision_flag_ev, done_ev};
  assign irq_clr = (wr_i && sel_ist) ? wdata_i[2:0] : 3'h0;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= irq_ev | (irq_st_r & ~irq_clr);
      irq_r <= ie & |(irq_st_r & irq_mask_r); // R01
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] stat_val;
  logic [7:0] rd_mux;

  // Unimplemented status bits read as zero
  assign stat_val = {done_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
  assign rd_mux = sel_ctrl ? ctrl_r :
                  sel_stat ? stat_val :
                  sel_data ? rx_buf_r :
                  sel_system_options_two ? system_options_two_r :
                  sel_ist ? {5'h00, irq_st_r} :
                  sel_imask ? {5'h00, irq_mask_r} : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  spms_pins_t pin_r;
  spms_pins_t oe_r;
  spms_pins_t pin_nxt;
  spms_pins_t drv;
  spms_pins_t oe_nxt;

  // Disabled port drives nothing; open drain only ever pulls low
  assign pin_nxt = '{sck: sck_r, mosi: out_bit, miso: out_bit};
  assign drv = '{sck: en & mst, mosi: en & mst, miso: slv_act}; // R02 R04
  assign oe_nxt = '{sck: drv.sck & (~od | ~pin_nxt.sck),
                    mosi: drv.mosi & (~od | ~pin_nxt.mosi),
                    miso: drv.miso & (~od | ~pin_nxt.miso)}; // R03

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= '0;
      oe_r <= '0;
    end else begin
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign pin_o = pin_r;
  assign pin_oe_o = oe_r;
  assign rdata_o = rdata_r;
  assign irq_o = irq_r;

endmodule

`default_nettype wire

// *** spms_port_checker.sv ***
/*
  Assertion checker for the serial port, bound to spms_port.
  Assumes it sees only the top ports; it shadows control writes itself.
*/
`timescale 1ns/10ps
`default_nettype none

module spms_port_checker
  import spms_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire spms_pins_t pin_i,
  input wire logic ss_n_i,
  input wire spms_pins_t pin_o,
  input wire spms_pins_t pin_oe_o
);
  // --------------------------------------------------------------
  // Shadow of control writes
  // --------------------------------------------------------------
  // A fault clears enable and master select behind this copy, so it only overstates those two
  logic [7:0] ctl_r;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_r <= CTRL_RST;
    end else if (wr_i && addr_i == SPMS_CTRL_OFS) begin
      ctl_r <= wdata_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_irq_needs_ie: assert property (
    !ctl_r[CTRL_IE] && !$past(ctl_r[CTRL_IE]) |-> !irq_o) else $error("irq with enable off");
  a_port_off_quiet: assert property (
    (!ctl_r[CTRL_EN]) [*3] |-> pin_oe_o == '0) else $error("pins driven while off");
  a_open_drain_low: assert property (
    ctl_r[CTRL_OD] && $past(ctl_r[CTRL_OD]) && $past(ctl_r[CTRL_OD], 2)
    |-> !(pin_oe_o.mosi && pin_o.mosi) && !(pin_oe_o.sck && pin_o.sck))
    else $error("open drain pin driven high");
  a_miso_unselected: assert property (
    ss_n_i [*5] |-> !pin_oe_o.miso) else $error("miso driven while unselected");
  a_fault_stops_clk: assert property (
    (ctl_r[CTRL_MS] && ctl_r[CTRL_EN] && !ss_n_i) [*6] |-> !pin_oe_o.sck)
    else $error("clock still driven after select fault");
  a_stat_unused_zero: assert property (
    $past(rd_i) && $past(addr_i) == SPMS_STAT_OFS |-> rdata_o[5] == 1'b0 && rdata_o[3:0] == 4'h0)
    else $error("unused status bits set");
  a_system_options_two_unused_zero: assert property (
    $past(rd_i) && $past(addr_i) == SPMS_SYSTEM_OPTIONS_TWO_OFS |-> (rdata_o & ~SYSTEM_OPTIONS_TWO_MASK) == 8'h00)
    else $error("unused option bits set");
  a_rdata_one_cycle: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside its cycle");

  c_irq: cover property ($rose(irq_o));
  c_sck_driven: cover property (pin_oe_o.sck && ctl_r[CTRL_MS]);
  c_done_read: cover property ($past(rd_i) && rdata_o[STAT_DONE]);
endmodule

bind spms_port spms_port_checker u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .pin_i(pin_i), .ss_n_i(ss_n_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

`default_nettype wire

// *** spms_slave_model.sv ***
/*
  Behavioural external peripheral on the far side of the port.
  Assumes the bench drives its select and the current clock mode.
*/
`timescale 1ns/10ps
`default_nettype none

module spms_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  // --------------------------------------------------------------
  // Shifter
  // --------------------------------------------------------------
  // Spare bit lets phase 1 present its first bit on the leading edge
  logic [8:0] sh_r;
  logic cs_q = 1'b1;
  // One process owns the shifter: a falling select loads it, clock edges
  // sample or shift; leading edge leaves the idle level
  always @(sck_i or cs_n_i) begin
    if (cs_q && !cs_n_i) begin
      sh_r = pha_i ? {1'b0, tx_i} : {tx_i, 1'b0};
      rx_o = 8'h00;
    end else if (!cs_n_i && ((sck_i != pol_i) != pha_i)) begin
      rx_o = {rx_o[6:0], mosi_i};
    end else if (!cs_n_i) begin
      sh_r = {sh_r[7:0], 1'b0};
    end
    cs_q = cs_n_i;
  end
  // Deselected line shows the inverse so stale data never passes
  assign miso_o = cs_n_i ? ~sh_r[8] : sh_r[8];
endmodule

`default_nettype wire

// *** tb_top.sv ***
/*
  Self-checking bench of the serial port in master mode with a model
  peripheral. Assumes pull-ups on all three serial lines.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import spms_pkg::*;
;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ss_n_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, m_tx = 8'h00, m_rx;
  logic irq_o, miso_m, slv_cs_n = 1'b1, m_pol = 1'b0, m_pha = 1'b0;
  spms_pins_t pin_o, pin_oe_o, pin_i;
  logic [7:0] divs [8] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h08, 8'h10, 8'h40, 8'h80};
  int errors = 0, samples_checked = 0;

  always #25 ref_clk_i = ~ref_clk_i;
  // Undriven lines float to the pull-up level
  assign pin_i = '{sck: pin_oe_o.sck ? pin_o.sck : 1'b1,
                   mosi: pin_oe_o.mosi ? pin_o.mosi : 1'b1,
                   miso: pin_oe_o.miso ? pin_o.miso : (slv_cs_n ? 1'b1 : miso_m)};

  spms_port uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pin_i(pin_i),
    .ss_n_i(ss_n_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  spms_slave_model u_slv (.sck_i(pin_i.sck), .mosi_i(pin_i.mosi), .cs_n_i(slv_cs_n),
    .pol_i(m_pol), .pha_i(m_pha), .tx_i(m_tx), .miso_o(miso_m), .rx_o(m_rx));

  // --------------------------------------------------------------
  // Bus and check helpers
  // --------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h seen %h", n, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    q = rdata_o;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  task automatic final_report;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] q;
    rd(SPMS_CTRL_OFS, q);
    chk("ctrl reset", CTRL_RST, q);
    rd(SPMS_SYSTEM_OPTIONS_TWO_OFS, q);
    chk("system_options_two reset", 8'h00, q);
    wr(SPMS_SYSTEM_OPTIONS_TWO_OFS, 8'hFF);
    rd(SPMS_SYSTEM_OPTIONS_TWO_OFS, q);
    chk("system_options_two bits", 8'h0C, q);
    wr(SPMS_STAT_OFS, 8'hFF);
    rd(SPMS_STAT_OFS, q);
    chk("status", 8'h00, q);
    rd(8'h30, q);
    chk("unmapped", 8'h00, q);
    wr(SPMS_CTRL_OFS, 8'h90);
    wr(SPMS_DATA_OFS, 8'h5A);
    repeat (300) @(posedge ref_clk_i);
    rd(SPMS_IRQ_ST_OFS, q);
    chk("xfer while off", 8'h00, q);
    $display("test regs done");
  endtask

  task automatic t_fault;
    logic [7:0] q;
    wr(SPMS_IRQ_MASK_OFS, 8'h00);
    wr(SPMS_CTRL_OFS, 8'hD0);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    ss_n_i <= 1'b1;
    rd(SPMS_CTRL_OFS, q);
    chk("ctrl after fault", 8'h80, q);
    chk("masked irq", 8'h00, {7'h00, irq_o});
    wr(SPMS_CTRL_OFS, 8'h80);
    rd(SPMS_STAT_OFS, q);
    chk("fault kept", 8'h10, q);
    wr(SPMS_CTRL_OFS, 8'h80);
    rd(SPMS_STAT_OFS, q);
    chk("fault cleared", 8'h00, q);
    wr(SPMS_IRQ_MASK_OFS, 8'h04);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("unmasked irq", 8'h01, {7'h00, irq_o});
    wr(SPMS_IRQ_ST_OFS, 8'h04);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("irq after clear", 8'h00, {7'h00, irq_o});
    $display("test fault done");
  endtask

  // Mode, order, rate and drive type all follow the select code
  task automatic t_xfer(input logic [2:0] s);
    logic [7:0] q, tx, stx;
    logic lsb;
    int n;
    lsb = s[0] ^ s[2];
    tx = 8'h35 ^ {s, s, 2'b01};
    stx = 8'hC6 + {5'h00, s};
    @(posedge ref_clk_i);
    m_tx <= stx;
    m_pol <= s[0];
    m_pha <= s[1];
    wr(SPMS_SYSTEM_OPTIONS_TWO_OFS, {4'h0, lsb, s[2], 2'b00});
    wr(SPMS_IRQ_MASK_OFS, 8'h01);
    wr(SPMS_CTRL_OFS, {2'b11, s[2], 1'b1, s[0], s[1], s[1:0]});
    // Select only after the clock line has settled at its new idle level
    repeat (4) @(posedge ref_clk_i);
    slv_cs_n <= 1'b0;
    wr(SPMS_DATA_OFS, tx);
    n = 0;
    if (s == 3'h3) begin
      wr(SPMS_DATA_OFS, 8'hFF);
      n = 2;
    end
    while (irq_o !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    samples_checked++;
    // Done reaches irq_o five cycles after the last serial clock edge
    if (n < 8 * divs[s] + 3 || n > 8 * divs[s] + 7) begin
      $display("unexpected cycles exp %0d seen %0d", 8 * divs[s] + 5, n);
      errors++;
    end
    rd(SPMS_DATA_OFS, q);
    chk("rx data", lsb ? rev(stx) : stx, q);
    chk("peer rx", lsb ? rev(tx) : tx, m_rx);
    chk("sck idle", {7'h00, s[0]}, {7'h00, pin_i.sck});
    rd(SPMS_STAT_OFS, q);
    chk("flags kept", s == 3'h3 ? 8'hC0 : 8'h80, q);
    rd(SPMS_DATA_OFS, q);
    rd(SPMS_STAT_OFS, q);
    chk("flags cleared", 8'h00, q);
    @(posedge ref_clk_i);
    slv_cs_n <= 1'b1;
    wr(SPMS_IRQ_ST_OFS, 8'h07);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("irq cleared", 8'h00, {7'h00, irq_o});
    $display("test xfer %0d done", s);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_regs();
    t_fault();
    for (int s = 0; s < 8; s++) begin
      t_xfer(s[2:0]);
    end
    final_report();
  end

  // Tests need under 5000 cycles; this cuts a hang well after that
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    final_report();
  end
endmodule

`default_nettype wire
